/* include/pxb_defines.svh */
// Constants of the priority pin crossbar
`ifndef PXB_DEFINES_SVH
`define PXB_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PXB_NUM_FN        17
`define PXB_NUM_XPINS     16
`define PXB_NUM_PINS      17

// ----------------------------------------
// Function indices in priority order
// ----------------------------------------
`define PXB_FN_TX         5'h00
`define PXB_FN_RX         5'h01
`define PXB_FN_SCK        5'h02
`define PXB_FN_MISO       5'h03
`define PXB_FN_MOSI       5'h04
`define PXB_FN_NSS        5'h05
`define PXB_FN_SDA        5'h06
`define PXB_FN_SCL        5'h07
`define PXB_FN_CMP        5'h08
`define PXB_FN_CMPA       5'h09
`define PXB_FN_CLK        5'h0a
`define PXB_FN_PCA_CHANNEL_0_PIN       5'h0b
`define PXB_FN_PCA_CHANNEL_1_PIN       5'h0c
`define PXB_FN_PCA_CHANNEL_2_PIN       5'h0d
`define PXB_FN_ECI        5'h0e
`define PXB_FN_T0         5'h0f
`define PXB_FN_T1         5'h10
`define PXB_FN_NONE       5'h1f

// ----------------------------------------
// Fixed pins and reset values
// ----------------------------------------
`define PXB_UART_TX_PIN   4
`define PXB_UART_RX_PIN   5
`define PXB_NSS_4WIRE_BIT 1
`define PXB_RST_PINS      17'h00000
`define PXB_RST_FN_IN     17'h1ffff
`define PXB_RST_ROUTED    17'h00000

`endif

/* include/pxb_pkg.sv */
// Types of the priority pin crossbar
`default_nettype none
`include "pxb_defines.svh"

package pxb_pkg;
  typedef logic [4:0]                       pxb_fn_type;
  typedef logic [`PXB_NUM_XPINS-1:0][4:0]   pxb_map_type;
endpackage

`default_nettype wire

/* rtl/pxb_crossbar.sv */
// Priority crossbar routing peripheral signals onto port pins
// Summary of operation
// - Functions placed in fixed priority: uart, spi, smbus, comparators, clock, pca, timers.
// - Each enabled function except uart and smbus gets the lowest free, unskipped port pin, if one is left.
// - A pin already given to a function is passed over afterwards.
// - A set skip-mask bit makes its pin count as taken.
// - Uart transmit always sits on port 0 pin 4, receive on pin 5.
// - Smbus enable claims two pins together, data then clock.
// - Uart enable claims transmit and receive together.
// - Unassigned pins stay general-purpose port I/O.
// - Slave select takes a pin only in four-wire mode.
// - Only port 0 and port 1 pins are assignable; port 2 pin is gpio.
// - Router disabled: all drivers off, pins are inputs.
// - Smbus pins always drive open-drain.
// - Every pin level is always readable on pin_level through a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "pxb_defines.svh"

module pxb_crossbar
  import pxb_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      router_enable,
  input  wire logic                      uart_enable,
  input  wire logic                      spi_enable,
  input  wire logic [1:0]                slave_select_mode,
  input  wire logic                      smbus_enable,
  input  wire logic                      comparator_enable,
  input  wire logic                      comparator_async_enable,
  input  wire logic                      core_clock_enable,
  input  wire logic [1:0]                pca_channel_count,
  input  wire logic                      pca_count_input_enable,
  input  wire logic                      timer0_input_enable,
  input  wire logic                      timer1_input_enable,
  input  wire logic [7:0]                port0_skip_mask,
  input  wire logic [7:0]                port1_skip_mask,
  input  wire logic [`PXB_NUM_PINS-1:0]  port_latch,
  input  wire logic [`PXB_NUM_PINS-1:0]  port_output_mode,
  input  wire logic [`PXB_NUM_FN-1:0]    func_out_data,
  input  wire logic [`PXB_NUM_FN-1:0]    func_out_enable,
  input  wire logic [`PXB_NUM_PINS-1:0]  pin_in,
  output logic      [`PXB_NUM_PINS-1:0]  pin_out,
  output logic      [`PXB_NUM_PINS-1:0]  pin_oe,
  output logic      [`PXB_NUM_PINS-1:0]  pin_level,
  output logic      [`PXB_NUM_FN-1:0]    func_in,
  output logic      [`PXB_NUM_FN-1:0]    routed_functions
);

  // ----------------------------------------
  // Priority placement
  // ----------------------------------------
  function automatic pxb_map_type pxb_route(input logic [`PXB_NUM_FN-1:0]   en,
                                            input logic [`PXB_NUM_XPINS-1:0] skip);
    pxb_map_type                 map;
    logic [`PXB_NUM_XPINS-1:0]   taken;
    logic                        got_a;
    logic                        got_b;
    logic [4:0]                  pa;
    logic [4:0]                  pb;
    map   = {`PXB_NUM_XPINS{`PXB_FN_NONE}};
    taken = skip;
    if (en[`PXB_FN_TX]) begin
      map[`PXB_UART_TX_PIN]   = `PXB_FN_TX;
      map[`PXB_UART_RX_PIN]   = `PXB_FN_RX;
      taken[`PXB_UART_TX_PIN] = 1'b1;
      taken[`PXB_UART_RX_PIN] = 1'b1;
    end
    for (int f = 2; f < `PXB_NUM_FN; f++) begin
      if (en[f] && (f != 32'(`PXB_FN_SCL))) begin
        got_a = 1'b0;
        got_b = 1'b0;
        pa    = 5'h00;
        pb    = 5'h00;
        for (int p = 0; p < `PXB_NUM_XPINS; p++) begin
          if (!taken[p]) begin
            if (!got_a) begin
              got_a = 1'b1;
              pa    = 5'(p);
            end else if (!got_b) begin
              got_b = 1'b1;
              pb    = 5'(p);
            end
          end
        end
        if (f == 32'(`PXB_FN_SDA)) begin
          if (got_a && got_b) begin
            map[pa[3:0]]   = `PXB_FN_SDA;
            map[pb[3:0]]   = `PXB_FN_SCL;
            taken[pa[3:0]] = 1'b1;
            taken[pb[3:0]] = 1'b1;
          end
        end else if (got_a) begin
          map[pa[3:0]]   = 5'(f);
          taken[pa[3:0]] = 1'b1;
        end
      end
    end
    return map;
  endfunction

  // ----------------------------------------
  // Enable vector
  // ----------------------------------------
  logic [`PXB_NUM_FN-1:0]   fn_en;

  always_comb begin
    fn_en                = '0;
    fn_en[`PXB_FN_TX]    = uart_enable;
    fn_en[`PXB_FN_RX]    = uart_enable;
    fn_en[`PXB_FN_SCK]   = spi_enable;
    fn_en[`PXB_FN_MISO]  = spi_enable;
    fn_en[`PXB_FN_MOSI]  = spi_enable;
    fn_en[`PXB_FN_NSS]   = spi_enable & slave_select_mode[`PXB_NSS_4WIRE_BIT];
    fn_en[`PXB_FN_SDA]   = smbus_enable;
    fn_en[`PXB_FN_SCL]   = smbus_enable;
    fn_en[`PXB_FN_CMP]   = comparator_enable;
    fn_en[`PXB_FN_CMPA]  = comparator_async_enable;
    fn_en[`PXB_FN_CLK]   = core_clock_enable;
    fn_en[`PXB_FN_PCA_CHANNEL_0_PIN]  = pca_channel_count >= 2'h1;
    fn_en[`PXB_FN_PCA_CHANNEL_1_PIN]  = pca_channel_count >= 2'h2;
    fn_en[`PXB_FN_PCA_CHANNEL_2_PIN]  = pca_channel_count == 2'h3;
    fn_en[`PXB_FN_ECI]   = pca_count_input_enable;
    fn_en[`PXB_FN_T0]    = timer0_input_enable;
    fn_en[`PXB_FN_T1]    = timer1_input_enable;
  end

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic [`PXB_NUM_PINS-1:0] sync1_ff;
  logic [`PXB_NUM_PINS-1:0] level_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_ff <= `PXB_RST_PINS;
      level_ff <= `PXB_RST_PINS;
    end else begin
      sync1_ff <= pin_in;
      level_ff <= sync1_ff;
    end
  end

  assign pin_level = level_ff;

  // ----------------------------------------
  // Mapping and pin drive
  // ----------------------------------------
  pxb_map_type              map_ff;
  pxb_map_type              nxt_map;
  logic [`PXB_NUM_PINS-1:0] pin_out_ff;
  logic [`PXB_NUM_PINS-1:0] nxt_pin_out;
  logic [`PXB_NUM_PINS-1:0] pin_oe_ff;
  logic [`PXB_NUM_PINS-1:0] nxt_pin_oe;
  logic [`PXB_NUM_FN-1:0]   func_in_ff;
  logic [`PXB_NUM_FN-1:0]   nxt_func_in;
  logic [`PXB_NUM_FN-1:0]   routed_ff;
  logic [`PXB_NUM_FN-1:0]   nxt_routed;

  always_comb begin
    pxb_fn_type fn;
    logic       dat;
    logic       drv;
    logic       odr;
    fn          = `PXB_FN_NONE;
    dat         = 1'b0;
    drv         = 1'b0;
    odr         = 1'b0;
    nxt_map     = pxb_route(fn_en, {port1_skip_mask, port0_skip_mask});
    nxt_pin_out = '0;
    nxt_pin_oe  = '0;
    nxt_func_in = `PXB_RST_FN_IN;
    nxt_routed  = '0;
    for (int p = 0; p < `PXB_NUM_PINS; p++) begin
      fn  = (p < `PXB_NUM_XPINS) ? nxt_map[p[3:0]] : `PXB_FN_NONE;
      if (fn == `PXB_FN_NONE) begin
        dat = port_latch[p];
        drv = 1'b1;
        odr = ~port_output_mode[p];
      end else begin
        dat = func_out_data[fn];
        drv = func_out_enable[fn];
        odr = ~port_output_mode[p] | (fn == `PXB_FN_SDA) | (fn == `PXB_FN_SCL);
        nxt_routed[fn]  = router_enable;
        nxt_func_in[fn] = router_enable ? level_ff[p] : 1'b1;
      end
      nxt_pin_out[p] = router_enable & dat & ~odr;
      nxt_pin_oe[p]  = router_enable & drv & (~odr | ~dat);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      map_ff     <= {`PXB_NUM_XPINS{`PXB_FN_NONE}};
      pin_out_ff <= `PXB_RST_PINS;
      pin_oe_ff  <= `PXB_RST_PINS;
      func_in_ff <= `PXB_RST_FN_IN;
      routed_ff  <= `PXB_RST_ROUTED;
    end else begin
      map_ff     <= nxt_map;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      func_in_ff <= nxt_func_in;
      routed_ff  <= nxt_routed;
    end
  end

  assign pin_out          = pin_out_ff;
  assign pin_oe           = pin_oe_ff;
  assign func_in          = func_in_ff;
  assign routed_functions = routed_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [`PXB_NUM_FN-1:0] chk_gap;
  logic                   chk_prio_bad;
  logic                   chk_od_bad;

  always_comb begin
    // Smbus left out: an unplaced pair may leave its single free pin to later functions
    chk_gap      = fn_en & ~routed_ff & ~17'h000c0;
    chk_prio_bad = (chk_gap != '0) && ((routed_ff & ~((chk_gap & (~chk_gap + 17'h1)) - 17'h1)) != '0);
    chk_od_bad   = 1'b0;
    for (int p = 0; p < `PXB_NUM_XPINS; p++) begin
      if ((map_ff[p] == `PXB_FN_SDA || map_ff[p] == `PXB_FN_SCL) && pin_out_ff[p]) begin
        chk_od_bad = 1'b1;
      end
    end
  end

  uart_fixed_a: assert property (router_enable && uart_enable |=>
    map_ff[`PXB_UART_TX_PIN] == `PXB_FN_TX && map_ff[`PXB_UART_RX_PIN] == `PXB_FN_RX)
    else $error("Uart lines not on fixed pins");
  disabled_off_a: assert property (!router_enable |=> pin_oe_ff == '0 && routed_ff == '0)
    else $error("Pin driven while router disabled");
  skip_honour_a: assert property (port0_skip_mask[0] |=> map_ff[0] == `PXB_FN_NONE)
    else $error("Skipped pin was assigned");
  first_pin_a: assert property (router_enable && spi_enable && !uart_enable &&
    port0_skip_mask == 8'h00 |=> map_ff[0] == `PXB_FN_SCK && map_ff[1] == `PXB_FN_MISO)
    else $error("Spi clock not on lowest free pin");
  nss_three_a: assert property (!slave_select_mode[`PXB_NSS_4WIRE_BIT] |=> !routed_ff[`PXB_FN_NSS])
    else $error("Slave select routed in three-wire mode");
  smbus_pair_a: assert property (routed_ff[`PXB_FN_SDA] == routed_ff[`PXB_FN_SCL])
    else $error("Smbus lines not claimed together");
  smbus_od_a: assert property (!chk_od_bad)
    else $error("Smbus pin driven high");
  prio_keep_a: assert property (router_enable ##1 $stable(fn_en) |-> !chk_prio_bad)
    else $error("Lower priority routed over higher");
  level_read_a: assert property (!rst ##1 !rst |=> pin_level == $past(pin_in, 2))
    else $error("Pin level not readable");
  port2_gpio_a: assert property (router_enable |=> pin_oe_ff[16] == (
    $past(port_output_mode[16]) | ~$past(port_latch[16])))
    else $error("Port 2 pin not plain gpio");

  uart_spi_c: cover property (router_enable && uart_enable && spi_enable ##1 routed_ff[`PXB_FN_MOSI]);
  crystal_skip_c: cover property (router_enable && port0_skip_mask == 8'h0c && smbus_enable);
  overflow_c: cover property (router_enable && fn_en == 17'h1ffff ##1 !routed_ff[`PXB_FN_T1]);

endmodule

`default_nettype wire

/* sim/pxb_pin_partner.sv */
// Far-side pin model: external drivers and pad level resolution
`timescale 1ns/1ps
`default_nettype none

module pxb_pin_partner (
  input  wire logic [16:0] pin_out,
  input  wire logic [16:0] pin_oe,
  input  wire logic [16:0] ext_level,
  output logic      [16:0] pin_in
);
  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  // Pad shows the chip while it drives, otherwise the external driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

`default_nettype wire

/* sim/priority_pin_crossbar_tb.sv */
// Self-checking bench of the priority pin crossbar
`timescale 1ns/1ps
`default_nettype none
`include "pxb_defines.svh"

module priority_pin_crossbar_tb;
  import pxb_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        sys_clk = 1'h0, rst = 1'h1, router_enable = 1'h0, uart_enable = 1'h0;
  logic        spi_enable = 1'h0, smbus_enable = 1'h0, comparator_enable = 1'h0;
  logic        comparator_async_enable = 1'h0, core_clock_enable = 1'h0;
  logic        pca_count_input_enable = 1'h0, timer0_input_enable = 1'h0;
  logic        timer1_input_enable = 1'h0;
  logic [1:0]  slave_select_mode = 2'h0, pca_channel_count = 2'h0;
  logic [7:0]  port0_skip_mask = 8'h00, port1_skip_mask = 8'h00;
  logic [16:0] port_latch = 17'h1a5c3, port_output_mode = 17'h1ffff;
  logic [16:0] func_out_data = 17'h0aaaa, func_out_enable = 17'h1fbff;
  logic [16:0] ext_level = 17'h0b4e1;
  logic [16:0] pin_in, pin_out, pin_oe, pin_level, func_in, routed_functions;
  logic [16:0] e_oe, e_out, e_lvl, e_fin, e_rt;
  pxb_map_type mp;
  int          error_cnt = 0, check_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  pxb_crossbar dut_u (.sys_clk, .rst, .router_enable, .uart_enable, .spi_enable,
    .slave_select_mode, .smbus_enable, .comparator_enable, .comparator_async_enable,
    .core_clock_enable, .pca_channel_count, .pca_count_input_enable, .timer0_input_enable,
    .timer1_input_enable, .port0_skip_mask, .port1_skip_mask, .port_latch,
    .port_output_mode, .func_out_data, .func_out_enable, .pin_in, .pin_out, .pin_oe,
    .pin_level, .func_in, .routed_functions);

  pxb_pin_partner far_u (.pin_out, .pin_oe, .ext_level, .pin_in);

  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  function automatic int free_pin(input logic [15:0] t);
    for (int p = 0; p < 16; p++) if (!t[p]) return p;
    return 16;
  endfunction

  // en: 0 router,1 uart,2 spi,4:3 ssel mode,5 smbus,6 cmp,7 cmp async,8 clk,10:9 pca,11..13 eci t0 t1
  task automatic model(input logic [13:0] en, input logic [15:0] sk);
    logic [15:0] t;
    logic [16:0] fe;
    logic [4:0]  f;
    logic        od, dr, da;
    int          a, b;
    t = sk;
    e_rt = '0;
    fe = {en[13:11], 3'((4'h1 << en[10:9]) - 4'h1), en[8:6], {2{en[5]}}, en[2] & en[4], {3{en[2]}}, 2'h0};
    for (int p = 0; p < 16; p++) mp[p] = `PXB_FN_NONE;
    if (en[1]) begin
      mp[4] = `PXB_FN_TX;
      mp[5] = `PXB_FN_RX;
      t[5:4] = 2'h3;
      e_rt[1:0] = 2'h3;
    end
    for (int i = 2; i < 17; i++) if (fe[i] && i != 7) begin
      a = free_pin(t);
      b = free_pin(t | (16'h1 << a));
      if (a < 16 && (i != 6 || b < 16)) begin
        mp[a] = 5'(i);
        t[a] = 1'h1;
        e_rt[i] = 1'h1;
        if (i == 6) begin
          mp[b] = `PXB_FN_SCL;
          e_rt[7] = 1'h1;
          t[b] = 1'h1;
        end
      end
    end
    if (!en[0]) e_rt = '0;
    for (int p = 0; p < 17; p++) begin
      f = (p < 16) ? mp[p] : `PXB_FN_NONE;
      dr = (f == `PXB_FN_NONE) ? 1'h1 : func_out_enable[f];
      da = (f == `PXB_FN_NONE) ? port_latch[p] : func_out_data[f];
      od = !port_output_mode[p] || f == `PXB_FN_SDA || f == `PXB_FN_SCL;
      e_oe[p] = en[0] & dr & (od ? !da : 1'h1);
      e_out[p] = en[0] & !od & da;
      e_lvl[p] = e_oe[p] ? e_out[p] : ext_level[p];
    end
    e_fin = '1;
    for (int p = 0; p < 16; p++) if (mp[p] != `PXB_FN_NONE && en[0]) e_fin[mp[p]] = e_lvl[p];
  endtask

  task automatic chk(input string nm, input logic [16:0] ex, input logic [16:0] got);
    check_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic run(input string nm, input logic [13:0] en, input logic [15:0] sk, input logic [16:0] md);
    @(posedge sys_clk);
    {slave_select_mode, spi_enable, uart_enable, router_enable} <= en[4:0];
    {core_clock_enable, comparator_async_enable, comparator_enable, smbus_enable} <= en[8:5];
    {pca_count_input_enable, pca_channel_count} <= en[11:9];
    {timer0_input_enable, timer1_input_enable} <= {en[12], en[13]};
    {port1_skip_mask, port0_skip_mask} <= sk;
    port_output_mode <= md;
    @(posedge sys_clk);
    #1;
    model(en, sk);
    chk("routed", e_rt, routed_functions);
    repeat (6) @(posedge sys_clk);
    #1;
    chk("routed", e_rt, routed_functions);
    chk("oe", e_oe, pin_oe);
    chk("out", e_out, pin_out);
    chk("func_in", e_fin, func_in);
    chk("level", e_lvl, pin_level);
    $display("Test %s done", nm);
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk("rst_oe", 17'h00000, pin_oe);
    chk("rst_fin", 17'h1ffff, func_in);
    chk("rst_rt", 17'h00000, routed_functions);
    run("spi3", 14'h0005, 16'h0000, 17'h1ffff);
    run("mix", 14'h0037, 16'h000c, 17'h0f0f0);
    run("all", 14'h3fff, 16'h0000, 17'h1ffff);
    run("smb_one", 14'h0061, 16'hfffe, 17'h1ffff);
    run("uart_skip", 14'h0043, 16'h0031, 17'h15555);
    run("off", 14'h3ffe, 16'h0000, 17'h1ffff);
    run("ssm01", 14'h000d, 16'h8001, 17'h00000);
    conclude();
  end

  initial begin
    #5000;
    error_cnt++;
    conclude();
  end
endmodule

`default_nettype wire
